// >>> filt_ptr_pkg.sv
package filt_ptr_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [3:0]  ADDR_GROUP_B = 4'h0;
    localparam logic [3:0]  ADDR_GROUP_C = 4'h4;
    localparam logic [15:0] PTR_RESET    = 16'h0000;
    localparam logic [31:0] READ_ZERO    = 32'h0000_0000;

    // ----------------------------------------
    // pointer encoding and filter indices
    // ----------------------------------------
    localparam logic [3:0] DEST_FIFO    = 4'hF;
    localparam logic [3:0] FIRST_FILTER = 4'h4;
    localparam logic [3:0] LAST_FILTER  = 4'hB;
    localparam int         FIELD_W      = 4;
    localparam int         NUM_FILTERS  = 8;
    localparam int         PER_REG      = 4;

    typedef struct packed {
        logic       valid;
        logic       to_fifo;
        logic [3:0] buffer;
    } dest_t;

endpackage : filt_ptr_pkg

// >>> can_filter_buffer_pointer.sv
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/1ps

module can_filter_buffer_pointer
(
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    // wishbone slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [3:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    // filter hit from matching logic
    input  wire logic        hit_valid_in,
    input  wire logic [3:0]  hit_filter_in,
    // destination to receive storage
    output filt_ptr_pkg::dest_t dest_out
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [15:0]         group_b_q;
    logic [15:0]         group_b_d;
    logic [15:0]         group_c_q;
    logic [15:0]         group_c_d;
    logic [31:0]         rdata_d;
    logic                ack_d;
    filt_ptr_pkg::dest_t dest_d;
    logic [3:0]          field_mux [filt_ptr_pkg::NUM_FILTERS];
    logic                req;
    logic                sel_b;
    logic                sel_c;
    logic [2:0]          hit_idx;

    assign req   = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign sel_b = (wb_adr_in == filt_ptr_pkg::ADDR_GROUP_B);
    assign sel_c = (wb_adr_in == filt_ptr_pkg::ADDR_GROUP_C);

    // ----------------------------------------
    // field split, one per filter
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < filt_ptr_pkg::NUM_FILTERS; g++)
        begin : g_field
            if (g < filt_ptr_pkg::PER_REG)
            begin : g_b
                // filters 4..7 low to high nibble
                assign field_mux[g] =
                    group_b_q[g*filt_ptr_pkg::FIELD_W +: 4];
            end
            else
            begin : g_c
                // filters 8..11 low to high nibble
                assign field_mux[g] = group_c_q[(g-filt_ptr_pkg::PER_REG)
                    *filt_ptr_pkg::FIELD_W +: 4];
            end
        end
    endgenerate

    assign hit_idx = 3'(hit_filter_in - filt_ptr_pkg::FIRST_FILTER);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        group_b_d = group_b_q;
        group_c_d = group_c_q;
        rdata_d   = wb_dat_out;
        ack_d     = req;
        if (req && wb_we_in)
        begin
            // only the two low lanes exist; upper lanes ignored
            if (sel_b && wb_sel_in[0]) group_b_d[7:0]  = wb_dat_in[7:0];
            if (sel_b && wb_sel_in[1]) group_b_d[15:8] = wb_dat_in[15:8];
            if (sel_c && wb_sel_in[0]) group_c_d[7:0]  = wb_dat_in[7:0];
            if (sel_c && wb_sel_in[1]) group_c_d[15:8] = wb_dat_in[15:8];
        end
        if (req)
        begin
            // unmapped reads return zero, still acked
            rdata_d = filt_ptr_pkg::READ_ZERO;
            if (sel_b) rdata_d = {16'h0000, group_b_q};
            if (sel_c) rdata_d = {16'h0000, group_c_q};
        end
        dest_d.valid   = 1'b0;
        dest_d.to_fifo = 1'b0;
        dest_d.buffer  = 4'h0;
        if (hit_valid_in && hit_filter_in >= filt_ptr_pkg::FIRST_FILTER
            && hit_filter_in <= filt_ptr_pkg::LAST_FILTER)
        begin
            dest_d.valid   = 1'b1;
            dest_d.buffer  = field_mux[hit_idx];
            dest_d.to_fifo = (field_mux[hit_idx]
                              == filt_ptr_pkg::DEST_FIFO);
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            group_b_q  <= filt_ptr_pkg::PTR_RESET;
            group_c_q  <= filt_ptr_pkg::PTR_RESET;
            wb_dat_out <= filt_ptr_pkg::READ_ZERO;
            wb_ack_out <= 1'b0;
            dest_out   <= '0;
        end
        else
        begin
            group_b_q  <= group_b_d;
            group_c_q  <= group_c_d;
            wb_dat_out <= rdata_d;
            wb_ack_out <= ack_d;
            dest_out   <= dest_d;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_fifo_code;
        @(posedge clk_sys_in) disable iff (rst_in)
        dest_out.valid |-> (dest_out.to_fifo == (dest_out.buffer == 4'hF));
    endproperty
    a_fifo_code: assert property (p_fifo_code)
        else $error("fifo flag does not match pointer code");

    property p_dest_b;
        @(posedge clk_sys_in) disable iff (rst_in)
        (hit_valid_in && hit_filter_in == 4'h5)
        |=> dest_out.valid && dest_out.buffer == $past(group_b_q[7:4]);
    endproperty
    a_dest_b: assert property (p_dest_b)
        else $error("filter 5 destination wrong");

    property p_dest_c;
        @(posedge clk_sys_in) disable iff (rst_in)
        (hit_valid_in && hit_filter_in == 4'h8)
        |=> dest_out.buffer == $past(group_c_q[3:0]);
    endproperty
    a_dest_c: assert property (p_dest_c)
        else $error("filter 8 destination wrong");

    property p_top_nibble;
        @(posedge clk_sys_in) disable iff (rst_in)
        (hit_valid_in && hit_filter_in == 4'hB)
        |=> dest_out.buffer == $past(group_c_q[15:12]);
    endproperty
    a_top_nibble: assert property (p_top_nibble)
        else $error("filter 11 destination wrong");

    property p_write_read;
        @(posedge clk_sys_in) disable iff (rst_in)
        (req && wb_we_in && sel_b && wb_sel_in[1:0] == 2'h3)
        |=> group_b_q == $past(wb_dat_in[15:0]);
    endproperty
    a_write_read: assert property (p_write_read)
        else $error("group b write lost");

    property p_no_hit;
        @(posedge clk_sys_in) disable iff (rst_in)
        (!hit_valid_in || hit_filter_in < 4'h4 || hit_filter_in > 4'hB)
        |=> !dest_out.valid;
    endproperty
    a_no_hit: assert property (p_no_hit)
        else $error("destination without hit");

endmodule : can_filter_buffer_pointer

// >>> tb.sv
`timescale 1ns/1ps
// ------------------------------
// pointer table bench
// ------------------------------
module tb;
    logic                clk_sys_in    = 1'b0;
    logic                rst_in        = 1'b1;
    logic                wb_cyc_in     = 1'b0;
    logic                wb_stb_in     = 1'b0;
    logic                wb_we_in      = 1'b0;
    logic [3:0]          wb_adr_in     = 4'h0;
    logic [3:0]          wb_sel_in     = 4'h0;
    logic [31:0]         wb_dat_in     = 32'h0000_0000;
    logic [31:0]         wb_dat_out;
    logic                wb_ack_out;
    logic                hit_valid_in  = 1'b0;
    logic [3:0]          hit_filter_in = 4'h0;
    filt_ptr_pkg::dest_t dest_out;
    int                  n_fail        = 0;
    int                  n_compared    = 0;
    int                  cycles        = 0;
    logic [31:0]         rd;
    logic [15:0]         grp_b         = 16'hFE21;
    logic [15:0]         grp_c         = 16'h7E90;
    logic [15:0]         nib;
    logic [5:0]          exp_d;

    always #25 clk_sys_in = ~clk_sys_in;

    can_filter_buffer_pointer u_can_filter_buffer_pointer (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in),
        .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
        .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
        .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
        .hit_valid_in(hit_valid_in), .hit_filter_in(hit_filter_in),
        .dest_out(dest_out));

    // ------------------------------
    // tasks
    // ------------------------------
    task check(input string name, input logic [31:0] seen,
               input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // entered and left right after a rising edge
    task wb(input logic we, input logic [3:0] adr, input logic [3:0] sel,
            input logic [31:0] dat);
        int n;
        n = 0;
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in  <= we;
        wb_adr_in <= adr;
        wb_sel_in <= sel;
        wb_dat_in <= dat;
        do
        begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        while (wb_ack_out !== 1'b1 && n < 20);
        @(posedge clk_sys_in);
        rd = wb_dat_out;
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask : wb

    // leaves dest_out settled after the taking edge
    task hit(input logic [3:0] f);
        hit_valid_in  <= 1'b1;
        hit_filter_in <= f;
        @(posedge clk_sys_in);
        hit_valid_in  <= 1'b0;
        #1;
    endtask : hit

    task test_done;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    // generous ceiling, the sequence needs under a hundred cycles
    always @(posedge clk_sys_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_fail++;
            test_done();
        end
    end

    // ------------------------------
    // sequence
    // ------------------------------
    initial
    begin
        repeat (6) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        wb(1'b0, filt_ptr_pkg::ADDR_GROUP_B, 4'hF, 32'h0000_0000);
        check("group_b", rd, 32'h0000_0000);
        wb(1'b0, filt_ptr_pkg::ADDR_GROUP_C, 4'hF, 32'h0000_0000);
        check("group_c", rd, 32'h0000_0000);
        for (int f = 4; f < 12; f++)
        begin
            hit(4'(f));
            check("dest_rst", 32'(dest_out), 32'h0000_0020);
            @(posedge clk_sys_in);
        end
        $display("test reset done");
        // upper half of the data bus must be dropped
        wb(1'b1, filt_ptr_pkg::ADDR_GROUP_B, 4'h3, {16'hABCD, grp_b});
        wb(1'b1, filt_ptr_pkg::ADDR_GROUP_C, 4'h3, {16'hABCD, grp_c});
        wb(1'b0, filt_ptr_pkg::ADDR_GROUP_B, 4'hF, 32'h0000_0000);
        check("group_b", rd, {16'h0000, grp_b});
        wb(1'b0, filt_ptr_pkg::ADDR_GROUP_C, 4'hF, 32'h0000_0000);
        check("group_c", rd, {16'h0000, grp_c});
        for (int f = 4; f < 12; f++)
        begin
            nib = (f < 8 ? grp_b : grp_c) >> (4 * (f % 4));
            exp_d = {1'b1, nib[3:0] == 4'hF, nib[3:0]};
            hit(4'(f));
            check("dest", 32'(dest_out), 32'(exp_d));
            @(posedge clk_sys_in);
        end
        hit(4'h3);
        check("valid_f3", 32'(dest_out.valid), 32'h0);
        @(posedge clk_sys_in);
        hit(4'hC);
        check("valid_f12", 32'(dest_out.valid), 32'h0);
        @(posedge clk_sys_in);
        $display("test routing done");
        wb(1'b1, filt_ptr_pkg::ADDR_GROUP_C, 4'h5, 32'hFFFF_FF00);
        wb(1'b0, filt_ptr_pkg::ADDR_GROUP_C, 4'hF, 32'h0000_0000);
        check("lane0", rd, 32'h0000_7E00);
        wb(1'b1, 4'h8, 4'hF, 32'hFFFF_FFFF);
        wb(1'b0, 4'h8, 4'hF, 32'h0000_0000);
        check("unmapped", rd, 32'h0000_0000);
        wb(1'b0, filt_ptr_pkg::ADDR_GROUP_B, 4'hF, 32'h0000_0000);
        check("group_b_kept", rd, {16'h0000, grp_b});
        $display("test lanes done");
        test_done();
    end
endmodule : tb
